//--- hdl/adc_channel_and_compare_control.sv
// Top of the converter control: Avalon-MM registers, channel select, compare level, result.
`timescale 1ns/1ns
module adc_channel_and_compare_control (
  input  wire logic                        clk_in,
  input  wire logic                        reset_in,
  input  wire logic [7:0]                  avs_address_in,
  input  wire logic                        avs_read_in,
  input  wire logic                        avs_write_in,
  input  wire logic [31:0]                 avs_writedata_in,
  input  wire logic [3:0]                  avs_byteenable_in,
  output logic      [31:0]                 avs_readdata_out,
  output logic                             avs_waitrequest_out,
  input  wire logic                        comparator_in,
  input  wire logic                        clock_stop_in,
  input  wire logic                        ce_reset_in,
  output adc_ctrl_pkg::analog_ctl_t        analog_ctl_out,
  output logic      [5:0]                  port_input_enable_out
);

  // Request and answer travel as structs internally.
  adc_ctrl_pkg::bus_req_t req;
  adc_ctrl_pkg::bus_rsp_t rsp;

  assign req.address    = avs_address_in;
  assign req.read       = avs_read_in;
  assign req.write      = avs_write_in;
  assign req.writedata  = avs_writedata_in;
  assign req.byteenable = avs_byteenable_in;

  // Register state.
  adc_ctrl_pkg::bus_phase_t phase_q;
  adc_ctrl_pkg::bus_phase_t phase_d;
  logic [3:0]               channel_q;
  logic [3:0]               channel_d;
  logic [5:0]               level_q;
  logic [5:0]               level_d;
  logic [31:0]              readdata_q;
  logic [31:0]              readdata_d;
  logic                     result_bit;
  logic                     string_power;
  logic                     sw_stop_pulse;
  logic                     sw_ce_pulse;
  logic                     stop_any;
  logic                     sel_channel;
  logic                     sel_level;
  logic                     sel_result;
  logic                     sel_reset;
  logic                     low_lane_write;

  // Address decode.
  assign sel_channel    = (req.address == adc_ctrl_pkg::channel_select_offset);
  assign sel_level      = (req.address == adc_ctrl_pkg::compare_level_offset);
  assign sel_result     = (req.address == adc_ctrl_pkg::compare_result_offset);
  assign sel_reset      = (req.address == adc_ctrl_pkg::reset_control_offset);
  assign low_lane_write = req.write && req.byteenable[0];

  // Software may also raise clock-stop or CE reset events through a register of its own.
  assign sw_stop_pulse = (phase_q == adc_ctrl_pkg::phase_answer) && low_lane_write && sel_reset
                         && req.writedata[adc_ctrl_pkg::reset_stop_bit];
  assign sw_ce_pulse   = (phase_q == adc_ctrl_pkg::phase_answer) && low_lane_write && sel_reset
                         && req.writedata[adc_ctrl_pkg::reset_ce_bit];
  assign stop_any      = clock_stop_in || sw_stop_pulse;

  // The string is powered during the sample cycle of a result read, so the comparator
  // settles against the tap before the outcome is latched; the cost is a fixed extra cycle.
  assign string_power = (phase_q == adc_ctrl_pkg::phase_sample) && req.read && sel_result;

  // Bus phase sequence: idle, sample, answer; waitrequest drops in answer.
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      adc_ctrl_pkg::phase_idle: begin
        if (req.read || req.write) begin
          phase_d = adc_ctrl_pkg::phase_sample;
        end
      end
      adc_ctrl_pkg::phase_sample: begin
        phase_d = adc_ctrl_pkg::phase_answer;
      end
      adc_ctrl_pkg::phase_answer: begin
        phase_d = adc_ctrl_pkg::phase_idle;
      end
      default: begin
        phase_d = adc_ctrl_pkg::phase_idle;
      end
    endcase
  end

  // Register writes take effect at the answer edge; clock stop beats a channel select write.
  always_comb begin
    channel_d = channel_q;
    level_d   = level_q;
    if ((phase_q == adc_ctrl_pkg::phase_answer) && low_lane_write) begin
      if (sel_channel) begin
        channel_d = {1'b0, req.writedata[2:0]};
      end
      if (sel_level) begin
        level_d = req.writedata[5:0];
      end
    end
    if (stop_any) begin
      channel_d = {1'b0, adc_ctrl_pkg::channel_stop_code};
    end
    // A CE reset leaves the channel select untouched by design.
    if (sw_ce_pulse || ce_reset_in) begin
      channel_d = channel_q;
      if (stop_any) begin
        channel_d = {1'b0, adc_ctrl_pkg::channel_stop_code};
      end
    end
  end

  // Read data is captured in the sample cycle so it stands with waitrequest low.
  always_comb begin
    readdata_d = readdata_q;
    if (phase_q == adc_ctrl_pkg::phase_sample) begin
      readdata_d = adc_ctrl_pkg::unmapped_read_value;
      if (req.read) begin
        if (sel_channel) begin
          readdata_d = {28'h0000000, 1'b0, channel_q[2:0]};
        end else if (sel_level) begin
          readdata_d = {26'h0, level_q};
        end else if (sel_result) begin
          readdata_d = {31'h0, comparator_in};
        end
      end
    end
  end

  // State registers; only power-on reset reaches them asynchronously.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      phase_q    <= adc_ctrl_pkg::phase_idle;
      channel_q  <= adc_ctrl_pkg::channel_por_value;
      level_q    <= adc_ctrl_pkg::level_reset_value;
      readdata_q <= adc_ctrl_pkg::unmapped_read_value;
    end else begin
      phase_q    <= phase_d;
      channel_q  <= channel_d;
      level_q    <= level_d;
      readdata_q <= readdata_d;
    end
  end

  // Pin routing and pull-down control.
  channel_decode u_decode (
    .channel_code_in       (channel_q[2:0]),
    .pin_connect_out       (analog_ctl_out.pin_connect),
    .pulldown_enable_out   (analog_ctl_out.pulldown_enable),
    .port_input_enable_out (port_input_enable_out)
  );

  // Latched outcome of the most recent powered comparison.
  compare_sample u_sample (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .sample_in     (string_power),
    .comparator_in (comparator_in),
    .result_out    (result_bit)
  );

  // The tap follows the stored level; power is gated to the result read only.
  assign analog_ctl_out.tap_select   = level_q;
  assign analog_ctl_out.string_power = string_power;

  // Bus answer.
  assign rsp.readdata    = readdata_q;
  assign rsp.waitrequest = (req.read || req.write) && (phase_q != adc_ctrl_pkg::phase_answer);

  assign avs_readdata_out    = rsp.readdata;
  assign avs_waitrequest_out = rsp.waitrequest;

  // Software performs the approximation loop; the block only holds level and outcome.
  // The latched outcome is kept for a future status view and for debug taps.
  logic unused_result;
  assign unused_result = result_bit;

endmodule // adc_channel_and_compare_control

//--- hdl/adc_ctrl_pkg.sv
// Package holding register offsets, field layouts, reset values and carrier types of the converter control.
package adc_ctrl_pkg;

  // Register byte addresses on the Avalon-MM bus.
  localparam logic [7:0] channel_select_offset = 8'h14;
  localparam logic [7:0] compare_result_offset = 8'h06;
  localparam logic [7:0] compare_level_offset  = 8'h02;
  localparam logic [7:0] reset_control_offset  = 8'h20;

  // Field positions and widths.
  localparam int         channel_code_width  = 3;
  localparam int         channel_reg_width   = 4;
  localparam int         level_width         = 6;
  localparam int         analog_pin_count    = 6;
  localparam int         pulldown_pin_count  = 4;
  localparam int         pulldown_first_code = 2;
  localparam int         reset_ce_bit        = 0;
  localparam int         reset_stop_bit      = 1;

  // Reset values.
  localparam logic [3:0] channel_por_value   = 4'h7;
  localparam logic [2:0] channel_stop_code   = 3'h7;
  localparam logic [5:0] level_reset_value   = 6'h00;

  // Answer to an unmapped read.
  localparam logic [31:0] unmapped_read_value = 32'h0000_0000;

  // Avalon-MM request from the bus master.
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } bus_req_t;

  // Avalon-MM answer back to the bus master.
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } bus_rsp_t;

  // Controls that leave the block toward the analog front end.
  typedef struct packed {
    logic [5:0] pin_connect;
    logic [3:0] pulldown_enable;
    logic [5:0] tap_select;
    logic       string_power;
  } analog_ctl_t;

  // Bus transfer phase, one-hot.
  typedef enum logic [2:0] {
    phase_idle   = 3'b001,
    phase_sample = 3'b010,
    phase_answer = 3'b100
  } bus_phase_t;

endpackage

//--- hdl/channel_decode.sv
// Decoder from the channel code to pin connection and pull-down controls.
`timescale 1ns/1ns
module channel_decode (
  input  wire logic [2:0] channel_code_in,
  output logic      [5:0] pin_connect_out,
  output logic      [3:0] pulldown_enable_out,
  output logic      [5:0] port_input_enable_out
);

  // One pin per code; codes 6 and 7 match nothing so every pin stays a port input.
  genvar pin_idx;
  generate
    for (pin_idx = 0; pin_idx < adc_ctrl_pkg::analog_pin_count; pin_idx++) begin : g_pin
      assign pin_connect_out[pin_idx] =
        (channel_code_in == 3'(pin_idx));
      assign port_input_enable_out[pin_idx] = ~pin_connect_out[pin_idx];
    end
    for (pin_idx = 0; pin_idx < adc_ctrl_pkg::pulldown_pin_count; pin_idx++) begin : g_pd
      // Selected pin loses its pull-down, all others keep it.
      assign pulldown_enable_out[pin_idx] =
        ~pin_connect_out[pin_idx + adc_ctrl_pkg::pulldown_first_code];
    end
  endgenerate

endmodule // channel_decode

//--- hdl/compare_sample.sv
// Sampler that catches the comparator outcome while the resistor string is powered.
`timescale 1ns/1ns
module compare_sample (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic sample_in,
  input  wire logic comparator_in,
  output logic      result_out
);

  logic result_q;
  logic result_d;

  // Hold the last outcome; refresh only in the cycle the string is powered.
  always_comb begin
    result_d = sample_in ? comparator_in : result_q;
  end

  // Register the outcome.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      result_q <= 1'b0;
    end else begin
      result_q <= result_d;
    end
  end

  assign result_out = result_q;

endmodule // compare_sample

//--- dv/adc_ctrl_checker.sv
// Checker of the converter control port behaviour, bound to the top module.
`timescale 1ns/1ns
module adc_ctrl_checker (
  input wire logic                       clk_in,
  input wire logic                       reset_in,
  input wire logic [7:0]                 avs_address_in,
  input wire logic                       avs_read_in,
  input wire logic                       avs_write_in,
  input wire logic [31:0]                avs_writedata_in,
  input wire logic [3:0]                 avs_byteenable_in,
  input wire logic [31:0]                avs_readdata_out,
  input wire logic                       avs_waitrequest_out,
  input wire logic                       comparator_in,
  input wire logic                       clock_stop_in,
  input wire logic                       ce_reset_in,
  input wire adc_ctrl_pkg::analog_ctl_t  analog_ctl_out,
  input wire logic [5:0]                 port_input_enable_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // A write counts only at its answer edge and with the low lane enabled.
  logic wr_ok;
  assign wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];

  // Every transfer waits exactly two cycles before its answer.
  wait_two_a: assert property ($rose(avs_read_in || avs_write_in) |->
    avs_waitrequest_out [*2] ##1 !avs_waitrequest_out) else $error("wrong wait length");
  channel_write_a: assert property (wr_ok && avs_address_in == 8'h14 && !clock_stop_in
    |=> analog_ctl_out.pin_connect == 6'(6'h01 << $past(avs_writedata_in[2:0])))
    else $error("channel write not decoded");
  pins_onehot_a: assert property ($onehot0(analog_ctl_out.pin_connect))
    else $error("several pins connected");
  port_free_a: assert property (port_input_enable_out == ~analog_ctl_out.pin_connect)
    else $error("port input wrongly disabled");
  pulldown_sel_a: assert property (
    analog_ctl_out.pulldown_enable == ~analog_ctl_out.pin_connect[5:2])
    else $error("pull-down state wrong");
  level_write_a: assert property (wr_ok && avs_address_in == 8'h02
    |=> analog_ctl_out.tap_select == $past(avs_writedata_in[5:0])) else $error("tap not loaded");
  power_read_a: assert property (analog_ctl_out.string_power |-> avs_read_in &&
    avs_address_in == 8'h06 ##1 !analog_ctl_out.string_power) else $error("string power stray");
  result_bit_a: assert property (analog_ctl_out.string_power
    |=> avs_readdata_out == {31'h0, $past(comparator_in)}) else $error("result bit wrong");
  stop_code_a: assert property (clock_stop_in |=> analog_ctl_out.pin_connect == 6'h00
    && analog_ctl_out.pulldown_enable == 4'hF) else $error("clock stop ignored");
endmodule // adc_ctrl_checker

bind adc_channel_and_compare_control adc_ctrl_checker chk_u (.clk_in(clk_in),
  .reset_in(reset_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .comparator_in(comparator_in),
  .clock_stop_in(clock_stop_in), .ce_reset_in(ce_reset_in), .analog_ctl_out(analog_ctl_out),
  .port_input_enable_out(port_input_enable_out));

//--- dv/analog_source_model.sv
// Model of the six analog sources and the comparator beyond the converter control.
`timescale 1ns/1ns
module analog_source_model (
  input  wire logic                      clk_in,
  input  wire adc_ctrl_pkg::analog_ctl_t ctl_in,
  input  wire logic [35:0]               volts_in,
  output logic                           comparator_out
);
  logic       junk_q = 1'b0;
  logic [5:0] v;

  // Unpowered string gives no valid outcome, so the output wanders every cycle.
  always_ff @(posedge clk_in) begin
    junk_q <= !junk_q;
  end

  // Pick the level of the connected pin, six bits per pin.
  always_comb begin
    v = 6'h00;
    for (int i = 0; i < 6; i++) begin
      if (ctl_in.pin_connect[i]) begin
        v = volts_in[i*6 +: 6];
      end
    end
  end

  assign comparator_out = (ctl_in.string_power && |ctl_in.pin_connect) ?
                          (v >= ctl_in.tap_select) : junk_q;
endmodule // analog_source_model

//--- dv/adc_channel_and_compare_control_tb.sv
// Self-checking testbench of the converter control.
`timescale 1ns/1ns
module adc_channel_and_compare_control_tb;
  logic                      clk_in = 1'b0;
  logic                      reset_in = 1'b1;
  logic                      rd = 1'b0, wr = 1'b0, stop = 1'b0, ce = 1'b0, cmp_o, wait_o;
  logic [7:0]                addr = 8'h00;
  logic [31:0]               wd = 32'h0, q, rdata;
  logic [35:0]               volts = 36'h0;
  logic [5:0]                pe, res, exp_pin;
  adc_ctrl_pkg::analog_ctl_t actl;
  int                        errors = 0, checks = 0;

  // Clock of 40 ns period.
  always #20 clk_in = ~clk_in;

  adc_channel_and_compare_control dut_u (.clk_in(clk_in), .reset_in(reset_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o),
    .comparator_in(cmp_o), .clock_stop_in(stop), .ce_reset_in(ce), .analog_ctl_out(actl),
    .port_input_enable_out(pe));
  analog_source_model src_u (.clk_in(clk_in), .ctl_in(actl), .volts_in(volts),
    .comparator_out(cmp_o));

  task automatic finish_test;
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
    end
  endtask

  // One transfer; an edge passes after release so strobes never toggle twice in a step.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    // Waitrequest is looked at mid-cycle, so the request stands through the answer edge.
    do @(negedge clk_in); while (wait_o !== 1'b0);
    @(posedge clk_in);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_in);
  endtask

  // Watchdog sized well above the about 165 cycles the tests need.
  initial begin
    repeat (5000) @(posedge clk_in);
    errors++;
    finish_test();
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    bus(0, 8'h14, 0); cmp(q, 32'h7);
    for (int c = 0; c < 8; c++) begin
      bus(1, 8'h14, 32'hFFFF_FFF8 | c);
      bus(0, 8'h14, 0); cmp(q, c);
      exp_pin = (c < 6) ? 6'(1 << c) : 6'h00;
      cmp(actl.pin_connect, exp_pin);
      cmp(pe, {26'h0, ~exp_pin});
      cmp(actl.pulldown_enable, {28'h0, ~exp_pin[5:2]});
    end
    bus(1, 8'h02, 32'hFFFF_FFE5);
    bus(0, 8'h02, 0); cmp(q, 32'h25);
    cmp(actl.tap_select, 6'h25);
    cmp(actl.string_power, 1'b0);
    bus(0, 8'h30, 0); cmp(q, 32'h0);
    // Software approximation on pin 3 held at level 41.
    volts <= 36'h0_00A4_0000;
    bus(1, 8'h14, 3);
    res = 6'h00;
    for (int b = 5; b >= 0; b--) begin
      bus(1, 8'h02, res | 6'(1 << b));
      bus(0, 8'h06, 0);
      if (q[0]) res = res | 6'(1 << b);
    end
    cmp(res, 6'h29);
    bus(1, 8'h14, 2);
    stop <= 1'b1;
    @(posedge clk_in);
    stop <= 1'b0;
    bus(0, 8'h14, 0); cmp(q, 32'h7);
    bus(1, 8'h14, 4);
    ce <= 1'b1;
    @(posedge clk_in);
    ce <= 1'b0;
    bus(0, 8'h14, 0); cmp(q, 32'h4);
    // A clock stop raised through the reset control register forces code 7 as well.
    bus(1, 8'h14, 5);
    bus(1, 8'h20, 2);
    bus(0, 8'h14, 0); cmp(q, 32'h7);
    finish_test();
  end
endmodule // adc_channel_and_compare_control_tb
